// ### core/acs_pkg.sv
// constants, field layouts, encodings and reset values of the calibration
// sequencer; assumes an APB master and a modulator that delivers raw words.
// How it works
// - four calibration kinds start whenever their code is written to op mode
// - each stored result is raw minus offset, then times full-scale coefficient
// - calibration start drives ready flag and data-out/ready pin high
// - calibration end updates coefficient, clears ready, pin low with CS, idles
// - internal calibrations route zero or full-scale level onto converter input
// - chop off: zero-scale calibrations last four or three data periods
// - chop on: internal zero-scale two periods, system zero-scale one settling
// - internal full-scale lasts one settling at gain one, two otherwise
// - system full-scale lasts one settling period at any gain
// - all four calibrations accepted at any filter word
// - clock-divide bit set doubles internal full-scale calibration time
// - coefficients readable anytime; writes only in idle or power-down
// - offset and full-scale coefficients are 24-bit readable, writable registers
`default_nettype none
package acs_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_FSCALE = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  localparam int MODE_OP_LSB = 0;
  localparam int MODE_SINC3_BIT = 4;
  localparam int MODE_CHOP_BIT = 5;
  localparam int MODE_CLKDIV_BIT = 6;
  localparam int MODE_GAIN_LSB = 8;
  localparam int MODE_FW_LSB = 16;
  localparam int STAT_RDY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_OP_LSB = 4;

  localparam int IRQ_W = 3;
  localparam int IRQ_CAL_DONE = 0;
  localparam int IRQ_CONV = 1;
  localparam int IRQ_REFUSED = 2;

  localparam int COEF_W = 24;
  localparam int FW_W = 10;
  localparam int PER_W = 5;
  localparam logic [9:0] FW_RST = 10'h060;
  localparam logic [23:0] OFFSET_RST = 24'h800000;
  localparam logic [23:0] FSCALE_RST = 24'h800000;
  localparam int UNITY_SHIFT = 23;
  localparam logic [23:0] SPAN_TARGET = 24'hFFFFFF;

  localparam logic [4:0] SETTLE_SINC4 = 5'h04;
  localparam logic [4:0] SETTLE_SINC3 = 5'h03;
  localparam logic [4:0] SETTLE_CHOP = 5'h02;

  typedef enum logic [2:0] {
    OP_CONT = 3'b000,
    OP_SINGLE = 3'b001,
    OP_IDLE = 3'b010,
    OP_PDOWN = 3'b011,
    OP_INT_ZERO = 3'b100,
    OP_INT_FULL = 3'b101,
    OP_SYS_ZERO = 3'b110,
    OP_SYS_FULL = 3'b111
  } acs_op_t;

  typedef enum logic [1:0] {
    SEL_EXT = 2'b00,
    SEL_ZERO = 2'b01,
    SEL_FULL = 2'b10
  } acs_sel_t;
endpackage : acs_pkg
`default_nettype wire

// ### core/acs_settle_timer.sv
// counts a number of output-data-rate periods of clks_per_fs * fw clocks;
// assumes start is a one-cycle pulse and restarts on every start.
`default_nettype none
module acs_settle_timer #(
  parameter int unsigned CLKS_PER_FS = 1024
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [4:0] periods_i,
  input wire logic [9:0] fw_i,
  output logic done_o
);
  localparam int CW = $clog2(CLKS_PER_FS * 1023 + 1);

  if (CLKS_PER_FS < 1) begin : g_chk
    $error("CLKS_PER_FS must be at least one");
  end

  typedef struct packed {
    logic busy;
    logic [4:0] left;
    logic [CW-1:0] len;
    logic [CW-1:0] cyc;
    logic done;
  } acs_tmr_t;

  acs_tmr_t s_q, s_d;
  logic [CW-1:0] len_new;

  always_comb begin
    // a zero filter word is treated as one to keep the period nonzero
    len_new = CW'(CLKS_PER_FS) * CW'((fw_i == 10'h000) ? 10'h001 : fw_i);
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.busy = (periods_i != 5'h00);
      s_d.left = periods_i;
      s_d.len = len_new;
      s_d.cyc = len_new - CW'(1);
    end else if (s_q.busy) begin
      if (s_q.cyc == '0) begin
        if (s_q.left == 5'h01) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.left = s_q.left - 5'h01;
          s_d.cyc = s_q.len - CW'(1);
        end
      end else begin
        s_d.cyc = s_q.cyc - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
endmodule // acs_settle_timer
`default_nettype wire

// ### core/acs_divider.sv
// sequential restoring divider, one quotient bit per clock;
// assumes divisor is nonzero; a new start abandons a running division.
`default_nettype none
module acs_divider #(
  parameter int NW = 48,
  parameter int DW = 24
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [NW-1:0] dividend_i,
  input wire logic [DW-1:0] divisor_i,
  output logic done_o,
  output logic [NW-1:0] quot_o
);
  if (NW < 2 || DW < 1) begin : g_chk
    $error("divider widths too small");
  end

  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
    logic [DW:0] rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] dvs;
    logic done;
  } acs_div_t;

  acs_div_t s_q, s_d;
  logic [DW:0] rem_sh;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    rem_sh = {s_q.rem[DW-1:0], s_q.quo[NW-1]};
    if (start_i) begin
      s_d.busy = 1'b1;
      s_d.cnt = 8'(NW);
      s_d.rem = '0;
      s_d.quo = dividend_i;
      s_d.dvs = divisor_i;
    end else if (s_q.busy) begin
      if (rem_sh >= {1'b0, s_q.dvs}) begin
        s_d.rem = rem_sh - {1'b0, s_q.dvs};
        s_d.quo = {s_q.quo[NW-2:0], 1'b1};
      end else begin
        s_d.rem = rem_sh;
        s_d.quo = {s_q.quo[NW-2:0], 1'b0};
      end
      s_d.cnt = s_q.cnt - 8'h01;
      if (s_q.cnt == 8'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
  assign quot_o = s_q.quo;
endmodule // acs_divider
`default_nettype wire

// ### core/acs_cal_seq.sv
// calibration sequencer with APB register slave, result scaling,
// coefficient store and interrupt; assumes raw_valid_i is a one-cycle
// pulse from the modulator/filter and cs_n_i is synchronous to clk_sys_i.
`default_nettype none
module acs_cal_seq #(
  parameter int unsigned CLKS_PER_FS = 1024
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic raw_valid_i,
  input wire logic [23:0] raw_data_i,
  input wire logic cs_n_i,
  output logic dout_rdy_o,
  output logic [1:0] in_sel_o,
  output logic irq_o
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_CAL = 2'b01,
    ST_DIV = 2'b10
  } acs_st_t;

  typedef struct packed {
    acs_st_t st;
    acs_pkg::acs_op_t op;
    logic sinc3;
    logic chop;
    logic clk_div;
    logic [2:0] gain;
    logic [9:0] fw;
    logic [23:0] offset;
    logic [23:0] fscale;
    logic [23:0] data;
    logic [23:0] raw_last;
    acs_pkg::acs_op_t cal_kind;
    logic rdy_n;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic dout_rdy;
    acs_pkg::acs_sel_t in_sel;
    logic irq;
  } acs_state_t;

  acs_state_t s_q, s_d;

  logic setup, acc, wr, rd, mode_wr, coef_lock, cal_start, tmr_done;
  logic div_done, conv_store;
  logic [4:0] periods;
  acs_pkg::acs_op_t wop;
  logic [24:0] diff;
  logic signed [49:0] prod;
  logic [23:0] scaled;
  logic [23:0] span;
  logic [47:0] quot;
  logic [2:0] ev;

  function automatic logic [4:0] cal_periods(
    input acs_pkg::acs_op_t op,
    input logic sinc3,
    input logic chop,
    input logic clk_div,
    input logic [2:0] gain
  );
    logic [4:0] p;
    if (chop) begin
      p = acs_pkg::SETTLE_CHOP;
    end else if (sinc3) begin
      p = acs_pkg::SETTLE_SINC3;
    end else begin
      p = acs_pkg::SETTLE_SINC4;
    end
    // system full-scale keeps one settling period at any gain
    if (op == acs_pkg::OP_INT_FULL) begin
      if (gain != 3'h0) begin
        p = p << 1;
      end
      if (clk_div) begin
        p = p << 1;
      end
    end
    return p;
  endfunction

  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i & s_q.pready;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign mode_wr = wr & (paddr_i == acs_pkg::ADDR_MODE);
  assign wop = acs_pkg::acs_op_t'(pwdata_i[acs_pkg::MODE_OP_LSB +: 3]);
  // any filter word is accepted; no check on the word at start
  assign cal_start = mode_wr & wop[2];
  assign periods = cal_periods(wop,
    pwdata_i[acs_pkg::MODE_SINC3_BIT], pwdata_i[acs_pkg::MODE_CHOP_BIT],
    pwdata_i[acs_pkg::MODE_CLKDIV_BIT],
    pwdata_i[acs_pkg::MODE_GAIN_LSB +: 3]);
  assign coef_lock = (s_q.st != ST_RUN) ||
    !((s_q.op == acs_pkg::OP_IDLE) || (s_q.op == acs_pkg::OP_PDOWN));
  assign conv_store = raw_valid_i && (s_q.st == ST_RUN) &&
    ((s_q.op == acs_pkg::OP_CONT) || (s_q.op == acs_pkg::OP_SINGLE));

  // offset removed first, then span scaled with unity at 2^23
  assign diff = {1'b0, raw_data_i} - {1'b0, s_q.offset};
  assign prod = $signed(diff) * $signed({1'b0, s_q.fscale});
  always_comb begin
    if (prod[49]) begin
      scaled = 24'h000000;
    end else if (|prod[48:47]) begin
      scaled = 24'hFFFFFF;
    end else begin
      scaled = prod[46:acs_pkg::UNITY_SHIFT];
    end
  end

  // a reading at or below the offset gives the largest gain, not a fault
  assign span = (s_q.raw_last > s_q.offset) ?
    (s_q.raw_last - s_q.offset) : 24'h000001;

  acs_settle_timer #(
    .CLKS_PER_FS(CLKS_PER_FS)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(cal_start),
    .periods_i(periods),
    .fw_i(pwdata_i[acs_pkg::MODE_FW_LSB +: 10]),
    .done_o(tmr_done)
  );

  acs_divider #(
    .NW(48),
    .DW(24)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(tmr_done && (s_q.st == ST_CAL) && !mode_wr &&
      s_q.cal_kind[0]),
    .dividend_i({1'b0, acs_pkg::SPAN_TARGET, 23'h000000}),
    .divisor_i(span),
    .done_o(div_done),
    .quot_o(quot)
  );

  always_comb begin
    s_d = s_q;
    ev = 3'h0;
    s_d.pready = setup;
    if (setup) begin
      s_d.prdata = 32'h00000000;
      s_d.pslverr = 1'b0;
      if (paddr_i == acs_pkg::ADDR_MODE) begin
        s_d.prdata[acs_pkg::MODE_OP_LSB +: 3] = s_q.op;
        s_d.prdata[acs_pkg::MODE_SINC3_BIT] = s_q.sinc3;
        s_d.prdata[acs_pkg::MODE_CHOP_BIT] = s_q.chop;
        s_d.prdata[acs_pkg::MODE_CLKDIV_BIT] = s_q.clk_div;
        s_d.prdata[acs_pkg::MODE_GAIN_LSB +: 3] = s_q.gain;
        s_d.prdata[acs_pkg::MODE_FW_LSB +: 10] = s_q.fw;
      end else if (paddr_i == acs_pkg::ADDR_STATUS) begin
        s_d.prdata[acs_pkg::STAT_RDY_BIT] = s_q.rdy_n;
        s_d.prdata[acs_pkg::STAT_BUSY_BIT] = (s_q.st != ST_RUN);
        s_d.prdata[acs_pkg::STAT_OP_LSB +: 3] = s_q.op;
      end else if (paddr_i == acs_pkg::ADDR_OFFSET) begin
        s_d.prdata[23:0] = s_q.offset;
        s_d.pslverr = pwrite_i && coef_lock;
      end else if (paddr_i == acs_pkg::ADDR_FSCALE) begin
        s_d.prdata[23:0] = s_q.fscale;
        s_d.pslverr = pwrite_i && coef_lock;
      end else if (paddr_i == acs_pkg::ADDR_DATA) begin
        s_d.prdata[23:0] = s_q.data;
      end else if (paddr_i == acs_pkg::ADDR_IRQ_STAT) begin
        s_d.prdata[2:0] = s_q.irq_stat;
      end else if (paddr_i == acs_pkg::ADDR_IRQ_MASK) begin
        s_d.prdata[2:0] = s_q.irq_mask;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    if (raw_valid_i && (s_q.st == ST_CAL)) begin
      s_d.raw_last = raw_data_i;
    end

    // reading the result hands the ready line back to not-ready
    if (rd && (paddr_i == acs_pkg::ADDR_DATA)) begin
      s_d.rdy_n = 1'b1;
    end
    if (conv_store) begin
      s_d.data = scaled;
      s_d.rdy_n = 1'b0;
      ev[acs_pkg::IRQ_CONV] = 1'b1;
      if (s_q.op == acs_pkg::OP_SINGLE) begin
        s_d.op = acs_pkg::OP_PDOWN;
      end
    end

    if ((s_q.st == ST_CAL) && tmr_done && !s_q.cal_kind[0]) begin
      s_d.offset = s_q.raw_last;
      s_d.op = acs_pkg::OP_IDLE;
      s_d.rdy_n = 1'b0;
      s_d.st = ST_RUN;
      ev[acs_pkg::IRQ_CAL_DONE] = 1'b1;
    end else if ((s_q.st == ST_CAL) && tmr_done) begin
      s_d.st = ST_DIV;
    end
    if ((s_q.st == ST_DIV) && div_done) begin
      s_d.fscale = (|quot[47:24]) ? 24'hFFFFFF : quot[23:0];
      s_d.op = acs_pkg::OP_IDLE;
      s_d.rdy_n = 1'b0;
      s_d.st = ST_RUN;
      ev[acs_pkg::IRQ_CAL_DONE] = 1'b1;
    end

    if (wr && (paddr_i == acs_pkg::ADDR_OFFSET)) begin
      if (coef_lock) begin
        ev[acs_pkg::IRQ_REFUSED] = 1'b1;
      end else begin
        s_d.offset = pwdata_i[23:0];
      end
    end
    if (wr && (paddr_i == acs_pkg::ADDR_FSCALE)) begin
      if (coef_lock) begin
        ev[acs_pkg::IRQ_REFUSED] = 1'b1;
      end else begin
        s_d.fscale = pwdata_i[23:0];
      end
    end
    if (wr && (paddr_i == acs_pkg::ADDR_IRQ_MASK)) begin
      s_d.irq_mask = pwdata_i[2:0];
    end

    // a mode write always wins; a non-calibration code aborts a calibration
    if (mode_wr) begin
      s_d.op = wop;
      s_d.sinc3 = pwdata_i[acs_pkg::MODE_SINC3_BIT];
      s_d.chop = pwdata_i[acs_pkg::MODE_CHOP_BIT];
      s_d.clk_div = pwdata_i[acs_pkg::MODE_CLKDIV_BIT];
      s_d.gain = pwdata_i[acs_pkg::MODE_GAIN_LSB +: 3];
      s_d.fw = pwdata_i[acs_pkg::MODE_FW_LSB +: 10];
      s_d.st = ST_RUN;
      if (cal_start) begin
        s_d.st = ST_CAL;
        s_d.cal_kind = wop;
        s_d.rdy_n = 1'b1;
      end
    end

    // new events win over a same-cycle write-one clear
    if (wr && (paddr_i == acs_pkg::ADDR_IRQ_STAT)) begin
      s_d.irq_stat = s_q.irq_stat & ~pwdata_i[2:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;

    if ((s_d.st == ST_CAL) && (s_d.cal_kind == acs_pkg::OP_INT_ZERO)) begin
      s_d.in_sel = acs_pkg::SEL_ZERO;
    end else if ((s_d.st == ST_CAL) &&
        (s_d.cal_kind == acs_pkg::OP_INT_FULL)) begin
      s_d.in_sel = acs_pkg::SEL_FULL;
    end else begin
      s_d.in_sel = acs_pkg::SEL_EXT;
    end
    s_d.dout_rdy = s_d.rdy_n | cs_n_i;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_RUN;
      s_q.op <= acs_pkg::OP_CONT;
      s_q.fw <= acs_pkg::FW_RST;
      s_q.offset <= acs_pkg::OFFSET_RST;
      s_q.fscale <= acs_pkg::FSCALE_RST;
      s_q.cal_kind <= acs_pkg::OP_IDLE;
      s_q.rdy_n <= 1'b1;
      s_q.dout_rdy <= 1'b1;
      s_q.in_sel <= acs_pkg::SEL_EXT;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready_o = s_q.pready;
  assign prdata_o = s_q.prdata;
  assign pslverr_o = s_q.pslverr;
  assign dout_rdy_o = s_q.dout_rdy;
  assign in_sel_o = s_q.in_sel;
  assign irq_o = s_q.irq;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_cal_busy;
    (s_q.st == ST_CAL) && s_q.rdy_n;
  endsequence
  sequence s_cal_idle;
    (s_q.op == acs_pkg::OP_IDLE) && !s_q.rdy_n && (s_q.st == ST_RUN);
  endsequence

  property p_cal_begin;
    cal_start |=> s_cal_busy ##1 dout_rdy_o;
  endproperty
  a_cal_begin: assert property (p_cal_begin)
    else $error("calibration start did not raise ready");

  property p_cal_end;
    ((s_q.st == ST_CAL) && tmr_done && !s_q.cal_kind[0] && !mode_wr)
      |=> s_cal_idle and (s_q.offset == $past(s_q.raw_last));
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("zero-scale end did not store offset and idle");

  property p_pin_cs;
    cs_n_i |=> dout_rdy_o;
  endproperty
  a_pin_cs: assert property (p_pin_cs)
    else $error("data-out/ready low without chip select");

  property p_insel;
    ((s_q.st == ST_CAL) && (s_q.cal_kind == acs_pkg::OP_INT_ZERO))
      |-> (in_sel_o == acs_pkg::SEL_ZERO);
  endproperty
  a_insel: assert property (p_insel)
    else $error("zero input not routed during internal zero cal");

  property p_conv;
    conv_store && !mode_wr |=> (s_q.data == $past(scaled)) && !s_q.rdy_n;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion not stored as scaled value");

  property p_refuse;
    (wr && (paddr_i == acs_pkg::ADDR_OFFSET) && (s_q.st == ST_RUN) &&
      coef_lock) |-> pslverr_o ##1 $stable(s_q.offset);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("coefficient write accepted while converting");

  property p_chop_zero;
    (cal_start && (wop == acs_pkg::OP_INT_ZERO) &&
      pwdata_i[acs_pkg::MODE_CHOP_BIT]) |-> (periods == 5'h02);
  endproperty
  a_chop_zero: assert property (p_chop_zero)
    else $error("chopped internal zero cal not two periods");

  property p_full_len;
    (cal_start && (wop == acs_pkg::OP_INT_FULL) &&
      !pwdata_i[acs_pkg::MODE_CHOP_BIT] &&
      !pwdata_i[acs_pkg::MODE_SINC3_BIT] &&
      pwdata_i[acs_pkg::MODE_CLKDIV_BIT] &&
      (pwdata_i[acs_pkg::MODE_GAIN_LSB +: 3] != 3'h0)) |-> (periods == 5'h10);
  endproperty
  a_full_len: assert property (p_full_len)
    else $error("internal full cal length wrong");

  // an unmasked event raises the line next cycle even against a w1c clear
  property p_irq;
    (|(ev & s_q.irq_mask)) && !(wr && (paddr_i == acs_pkg::ADDR_IRQ_MASK))
      |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked event did not raise the interrupt");
endmodule // acs_cal_seq
`default_nettype wire

// ### verif/acs_host_model.sv
// far-side model: analog front end giving a raw word every fourth clock
// assumes in_sel_i carries the sequencer's input route codes
`default_nettype none
module acs_host_model #(
  parameter logic [23:0] ZERO_LVL = 24'h000100,
  parameter logic [23:0] FULL_LVL = 24'hF00000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [1:0] in_sel_i,
  input wire logic [23:0] ext_lvl_i,
  output logic raw_valid_o,
  output logic [23:0] raw_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [23:0] lvl;
  // routed level wins over the pins; system levels come from the host
  assign lvl = (in_sel_i == 2'b01) ? ZERO_LVL :
               (in_sel_i == 2'b10) ? FULL_LVL : ext_lvl_i;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      raw_valid_o <= 1'b0;
      raw_data_o <= 24'h000000;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      raw_valid_o <= (cnt_q == 2'h3);
      // between words the data bus shows no stale value
      raw_data_o <= (cnt_q == 2'h3) ? lvl : ~lvl;
    end
  end
endmodule // acs_host_model
`default_nettype wire

// ### verif/acs_cal_seq_tb_top.sv
// self-checking bench of the calibration sequencer with an integer model
// assumes the host model feeds raw words; the bench is the apb master
`default_nettype none
module acs_cal_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPF = 2;
  localparam int FW = 16;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic cs_n = 1'b0;
  logic [23:0] ext = 24'h000000;
  logic pready, pslverr, raw_valid, dout_rdy, irq;
  logic [31:0] prdata;
  logic [23:0] raw_data;
  logic [1:0] in_sel;
  logic [31:0] r;
  logic e;
  int err_count = 0;
  int tests_run = 0;
  longint off = 64'h800000;
  longint fs = 64'h800000;
  longint lvl;
  int n;
  int t;
  always #2 clk_sys_i = ~clk_sys_i;
  acs_cal_seq #(.CLKS_PER_FS(CPF)) i_acs_cal_seq (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .raw_valid_i(raw_valid), .raw_data_i(raw_data),
    .cs_n_i(cs_n), .dout_rdy_o(dout_rdy), .in_sel_o(in_sel), .irq_o(irq));
  acs_host_model i_acs_host_model (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .in_sel_i(in_sel),
    .ext_lvl_i(ext), .raw_valid_o(raw_valid), .raw_data_o(raw_data));
  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // called just after a rising edge; returns one edge after the answer
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      chk("pready", 32'h0, 32'h1);
      print_verdict();
    end
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input string nm,
    input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(nm, r, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic xe);
    apb(1'b1, a, d);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask
  task automatic cal(input logic [2:0] op, input logic s3, input logic ch,
    input logic cd, input logic [2:0] g);
    int p;
    longint v;
    longint sp;
    p = ch ? 2 : (s3 ? 3 : 4);
    p = (op == 3'b101) ? p * (g != 3'h0 ? 2 : 1) * (cd ? 2 : 1) : p;
    t = p * CPF * FW + (op[0] ? 49 : 0);
    v = op[0] ? 64'h400000 + $urandom_range(0, 32'hBFFFFF)
              : $urandom_range(0, 32'hFFF);
    ext <= 24'(v);
    lvl = op[1] ? v : (op[0] ? 64'hF00000 : 64'h100);
    @(posedge clk_sys_i);
    wr(acs_pkg::ADDR_MODE, {6'h00, 10'(FW), 5'h00, g, 1'b0, cd, ch, s3,
      1'b0, op}, 1'b0);
    rd(acs_pkg::ADDR_STATUS, "status busy", {25'h0, op, 4'h3});
    chk("dout_rdy busy", {31'h0, dout_rdy}, 32'h1);
    chk("in_sel", {30'h0, in_sel}, {30'h0, op[1] ? 2'b00 :
      (op[0] ? 2'b10 : 2'b01)});
    n = 4;
    while (dout_rdy !== 1'b0 && n < t + 60) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("cal time", {31'h0, n >= t - 2 && n <= t + 6},
      32'h1);
    if (n >= t + 60) begin
      print_verdict();
    end
    sp = lvl - off;
    sp = sp < 1 ? 1 : sp;
    sp = (64'hFFFFFF << 23) / sp;
    fs = op[0] ? (sp > 64'hFFFFFF ? 64'hFFFFFF : sp) : fs;
    off = op[0] ? off : lvl;
    rd(acs_pkg::ADDR_OFFSET, "offset", 32'(off));
    rd(acs_pkg::ADDR_FSCALE, "fscale", 32'(fs));
    rd(acs_pkg::ADDR_STATUS, "status idle", 32'h00000020);
    apb(1'b0, acs_pkg::ADDR_IRQ_STAT, 32'h00000000);
    chk("cal irq", {31'h0, r[0]}, 32'h1);
    wr(acs_pkg::ADDR_IRQ_STAT, 32'h00000007, 1'b0);
    cs_n <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("dout_rdy cs high", {31'h0, dout_rdy}, 32'h1);
    cs_n <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("dout_rdy cs low", {31'h0, dout_rdy}, 32'h0);
  endtask
  initial begin
    void'($urandom(32'h0D60E384));
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(acs_pkg::ADDR_MODE, "mode rst", 32'h00600000);
    rd(acs_pkg::ADDR_STATUS, "status rst", 32'h00000001);
    rd(acs_pkg::ADDR_OFFSET, "offset rst", 32'h00800000);
    rd(acs_pkg::ADDR_FSCALE, "fscale rst", 32'h00800000);
    // zero-scale runs precede every full-scale run
    cal(3'b100, 1'b0, 1'b0, 1'b0, 3'h0);
    cal(3'b110, 1'b1, 1'b0, 1'b0, 3'h0);
    cal(3'b100, 1'b0, 1'b1, 1'b0, 3'h0);
    cal(3'b110, 1'b0, 1'b1, 1'b0, 3'h0);
    cal(3'b101, 1'b0, 1'b0, 1'b0, 3'h0);
    cal(3'b101, 1'b0, 1'b0, 1'b1, 3'h3);
    cal(3'b111, 1'b0, 1'b0, 1'b0, 3'h2);
    lvl = off + $urandom_range(1, 32'hFFFF);
    ext <= 24'(lvl);
    wr(acs_pkg::ADDR_MODE, {6'h00, 10'(FW), 16'h0000}, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    lvl = ((lvl - off) * fs) >> 23;
    rd(acs_pkg::ADDR_DATA, "data",
      32'(lvl > 64'hFFFFFF ? 64'hFFFFFF : lvl));
    wr(acs_pkg::ADDR_OFFSET, 32'h00123456, 1'b1);
    rd(acs_pkg::ADDR_OFFSET, "offset kept", 32'(off));
    wr(acs_pkg::ADDR_IRQ_MASK, 32'h00000004, 1'b0);
    @(posedge clk_sys_i);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(acs_pkg::ADDR_IRQ_STAT, 32'h00000004, 1'b0);
    @(posedge clk_sys_i);
    chk("irq clear", {31'h0, irq}, 32'h0);
    wr(8'h1C, 32'h00000000, 1'b1);
    // single conversion drops to power-down, where coefficients unlock
    lvl = off + $urandom_range(1, 32'hFFFF);
    ext <= 24'(lvl);
    wr(acs_pkg::ADDR_MODE, {6'h00, 10'(FW), 16'h0001}, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    rd(acs_pkg::ADDR_STATUS, "status single", 32'h00000030);
    lvl = ((lvl - off) * fs) >> 23;
    rd(acs_pkg::ADDR_DATA, "data single",
      32'(lvl > 64'hFFFFFF ? 64'hFFFFFF : lvl));
    rd(acs_pkg::ADDR_STATUS, "status read", 32'h00000031);
    rd(acs_pkg::ADDR_IRQ_STAT, "irq conv", 32'h00000002);
    off = $urandom_range(0, 32'hFFFFFF);
    wr(acs_pkg::ADDR_OFFSET, 32'(off), 1'b0);
    // coefficients lock while calibrating; an abort leaves them alone
    wr(acs_pkg::ADDR_MODE, {6'h00, 10'(FW), 16'h0004}, 1'b0);
    wr(acs_pkg::ADDR_OFFSET, 32'h00000000, 1'b1);
    chk("irq refused", {31'h0, irq}, 32'h1);
    wr(acs_pkg::ADDR_MODE, {6'h00, 10'(FW), 16'h0002}, 1'b0);
    rd(acs_pkg::ADDR_STATUS, "status abort", 32'h00000021);
    repeat (140) @(posedge clk_sys_i);
    rd(acs_pkg::ADDR_OFFSET, "offset abort", 32'(off));
    wr(acs_pkg::ADDR_MODE, {6'h00, 10'(FW), 16'h0002}, 1'b0);
    lvl = $urandom_range(0, 32'hFFFFFF);
    wr(acs_pkg::ADDR_OFFSET, 32'(lvl), 1'b0);
    rd(acs_pkg::ADDR_OFFSET, "offset idle", 32'(lvl));
    wr(acs_pkg::ADDR_FSCALE, 32'(lvl ^ 64'h5A5A5A), 1'b0);
    rd(acs_pkg::ADDR_FSCALE, "fscale idle", 32'(lvl ^ 64'h5A5A5A));
    print_verdict();
  end
endmodule // acs_cal_seq_tb_top
`default_nettype wire
